// File: hdl/fap_pkg.sv
// constants, field layouts and enumerations of the arithmetic processor
// assumes a 100 MHz sys_clk and a host on a plain strobe port
package fap_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_NS = 10;
    localparam int INSTR_NS = 175;
    localparam int INSTR_CYC = INSTR_NS / CLK_NS;
    localparam int TRF_NS = 25;
    localparam int TRF_CYC = TRF_NS / CLK_NS;
    // ************************************************************
    // sizes
    // ************************************************************
    localparam int FW = 16;
    localparam int FIELDS = 5;
    localparam int PM_W = FW * FIELDS;
    localparam int PM_DEPTH = 1024;
    localparam int PM_AW = 10;
    localparam int TRF_DEPTH = 128;
    localparam int TRF_AW = 7;
    // ************************************************************
    // host address map
    // ************************************************************
    localparam logic [15:0] ADDR_STATUS = 16'h0000;
    localparam logic [15:0] ADDR_CTRL = 16'h0001;
    localparam logic [15:0] ADDR_LOAD = 16'h0002;
    localparam logic [15:0] ADDR_STORE = 16'h0003;
    localparam logic [15:0] ADDR_PC = 16'h0004;
    localparam int PM_SEL_BIT = 15;
    localparam int PM_IDX_LSB = 3;
    localparam int FLD_W = 3;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_PC_LSB = 1;
    // ************************************************************
    // status word
    // ************************************************************
    localparam int PSW_PAUSE_LSB = 0;
    localparam int PAUSE_W = 3;
    localparam int PSW_PRESENT = 8;
    localparam int PSW_ACTIVE = 9;
    localparam int PSW_NEG = 13;
    localparam int PSW_POS = 14;
    localparam int PSW_ANY = 15;
    // ************************************************************
    // instruction fields
    // ************************************************************
    localparam logic [15:0] MASK_F0 = 16'hBFFE;
    localparam logic [15:0] MASK_MV = 16'hFE7F;
    localparam int I_HALT = 15;
    localparam int I_PAUSE_LSB = 11;
    localparam int I_MODE_LSB = 9;
    localparam int I_NEG = 8;
    localparam int I_SUBB = 7;
    localparam int I_USEB = 6;
    localparam int I_MUL_LSB = 4;
    localparam int I_ADD = 3;
    localparam int I_ADDSUB = 2;
    localparam int I_ADDE = 1;
    localparam int MV_VALID = 15;
    localparam int MV_SRC_LSB = 12;
    localparam int MV_DST_LSB = 9;
    localparam int MV_SEL_W = 3;
    // ************************************************************
    // arithmetic
    // ************************************************************
    localparam int FRAC_SH = 15;
    localparam int FASL_SH = 14;
    localparam int FRACTION_OP_SHIFT_RIGHT_SH = 16;
    localparam logic [16:0] FRAC_ONE = 17'h0_8000;
    localparam logic [16:0] INT_ONE = 17'h0_0001;
    localparam logic signed [35:0] POS_LIM = 36'sh0_0000_7FFF;
    localparam logic signed [35:0] NEG_LIM = 36'shF_FFFF_8000;
    localparam logic signed [35:0] ONE36 = 36'sh0_0000_0001;
    localparam logic [15:0] SAT_MAX = 16'h7FFF;
    localparam logic [15:0] SAT_MIN = 16'h8000;

    typedef enum logic [1:0] {
        MODE_FA = 2'h0, MODE_FASL = 2'h1, MODE_FRACTION_OP_SHIFT_RIGHT = 2'h2, MODE_IA = 2'h3
    } fap_mode_t;
    typedef enum logic [1:0] {
        MUL_ZERO = 2'h0, MUL_C = 2'h1, MUL_MAGC = 2'h2, MUL_ONE = 2'h3
    } fap_mul_t;
    typedef enum logic [2:0] {
        R_A, R_B, R_C, R_D, R_E, R_RS, R_LS, R_T
    } fap_reg_t;
    typedef enum logic [2:0] {
        S_IDLE, S_FETCH, S_DECODE, S_MOVE, S_ARITH, S_PAUSE
    } fap_state_t;
endpackage

// File: hdl/fap_prog_mem.sv
// program memory: five 16-bit field arrays, one host port, one fetch port
// assumes host read and write never fall in the same cycle
module fap_prog_mem import fap_pkg::*; (
    input wire logic sys_clk,
    input wire logic ce,
    input wire logic host_we,
    input wire logic [PM_AW-1:0] host_idx,
    input wire logic [FLD_W-1:0] host_fld,
    input wire logic [FW-1:0] host_wdata,
    output logic [FW-1:0] host_rdata,
    input wire logic [PM_AW-1:0] exec_idx,
    output logic [PM_W-1:0] exec_rdata
);
    logic [FW-1:0] hword [FIELDS];
    logic [FLD_W-1:0] fld_q;

    // ************************************************************
    // one array per field
    // ************************************************************
    for (genvar i = 0; i < FIELDS; i++) begin : g_fld
        logic [FW-1:0] mem [PM_DEPTH];
        always_ff @(posedge sys_clk) begin
            if (ce) begin
                if (host_we && host_fld == FLD_W'(i)) begin
                    mem[host_idx] <= host_wdata;
                end
                hword[i] <= mem[host_idx];
                exec_rdata[i*FW +: FW] <= mem[exec_idx];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ce) begin
            fld_q <= host_fld;
        end
    end

    // fields past the fifth read as zero
    assign host_rdata = (fld_q < FLD_W'(FIELDS)) ? hword[fld_q] : '0;
endmodule

// File: hdl/fap_tmp_regs.sv
// temporary register file, one write port, one registered read port
// assumes the owner drives the read address one cycle before use
module fap_tmp_regs import fap_pkg::*; (
    input wire logic sys_clk,
    input wire logic ce,
    input wire logic we,
    input wire logic [TRF_AW-1:0] waddr,
    input wire logic [FW-1:0] wdata,
    input wire logic [TRF_AW-1:0] raddr,
    output logic [FW-1:0] rdata
);
    logic [FW-1:0] mem [TRF_DEPTH];

    always_ff @(posedge sys_clk) begin
        if (ce) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule

// File: hdl/fap_arith_processor.sv
// fixed-point arithmetic processor: sequencer, datapath, host registers
// assumes a host on the strobe port in the sys_clk domain
// Function
// - one arithmetic instruction completes within 175 ns
// - 128-word temporary file, accessed within 25 ns
// - moves run concurrently with the arithmetic of the same instruction
// - bus traffic only through bus store and bus load registers
// - status low three bits give pause count; bit 8 shows present
// - status bit 9 set while active
// - status bits 13, 14, 15 latch negative, positive, any overflow
// - error flags stay set until a status read clears them
// - status word is read-only
// - negative overflow when result below 16-bit range
// - positive overflow when result above 16-bit range
// - any overflow when either overflow occurs
// - enable bits 13..15 gate errors onto the error line
// - write-only enable shares the status address
// - program memory of 1024 instructions, five 16-bit fields each
// - each field readable and writable by the host
// - unused instruction bits ignore ones and read zero
// - an instruction holds arithmetic, four move slots and a pause
// - no-op or zero outcome loads zero into the result
// - D copied into E in the first move subinterval
// - arithmetic in bits 10..1; mode 00 fraction, 11 integer, 10 shr
// - two's-complement operands, fraction or integer mode
// - fraction operands and result span -1.0 to 1.0 minus one lsb
// - 17 by 17 multiply, top bit dropped, 33-bit product kept
module fap_arith_processor import fap_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [15:0] addr,
    input wire logic [FW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [FW-1:0] rdata,
    output logic arith_error_line
);
    typedef struct packed {
        fap_state_t st;
        logic [PM_AW-1:0] pc;
        logic [1:0] slot;
        logic ph;
        logic [4:0] cyc;
        logic [PM_W-1:0] instr;
        logic [FW-1:0] a, b, c, d, e, r, s, l;
        logic signed [35:0] prod;
        logic [PAUSE_W-1:0] pause;
        logic run;
        logic neg_f, pos_f, any_f;
        logic [FW-1:0] en;
        logic [FW-1:0] rdata;
        logic sel_pm;
        logic err_line;
    } fap_core_t;

    fap_core_t q, next_q;
    logic [PM_W-1:0] pm_exec;
    logic [FW-1:0] pm_rdata, tmp_rdata, tmp_wdata, mv, w0, src_v, processor_status_word;
    logic [FW-1:0] pm_wdata;
    logic pm_we, tmp_we, tmp_re, st_rd, ev_neg, ev_pos;
    logic [TRF_AW-1:0] tmp_waddr, tmp_raddr;
    logic signed [16:0] sum17, mul17, bx, cx;
    logic signed [33:0] prod34;
    logic signed [35:0] p36, aln, acc, rnd;
    int sh;

    // ************************************************************
    // memories
    // ************************************************************
    fap_prog_mem u_pm (
        .sys_clk(sys_clk),
        .ce(ce),
        .host_we(pm_we),
        .host_idx(addr[PM_IDX_LSB +: PM_AW]),
        .host_fld(addr[FLD_W-1:0]),
        .host_wdata(pm_wdata),
        .host_rdata(pm_rdata),
        .exec_idx(q.pc),
        .exec_rdata(pm_exec)
    );

    fap_tmp_regs u_trf (
        .sys_clk(sys_clk),
        .ce(ce),
        .we(tmp_we),
        .waddr(tmp_waddr),
        .wdata(tmp_wdata),
        .raddr(tmp_raddr),
        .rdata(tmp_rdata)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_q = q;
        w0 = q.instr[FW-1:0];
        mv = q.instr[FW*(int'(q.slot)+1) +: FW];
        tmp_we = 1'b0;
        tmp_waddr = mv[TRF_AW-1:0];
        tmp_raddr = mv[TRF_AW-1:0];
        tmp_wdata = '0;
        tmp_re = 1'b0;
        pm_we = 1'b0;
        pm_wdata = '0;
        ev_neg = 1'b0;
        ev_pos = 1'b0;
        src_v = '0;
        sum17 = '0;
        mul17 = '0;
        prod34 = '0;
        p36 = '0;
        aln = '0;
        acc = '0;
        rnd = '0;
        sh = 0;
        bx = {q.b[FW-1], q.b};
        cx = {q.c[FW-1], q.c};
        if (q.st != S_IDLE && q.st != S_PAUSE && q.cyc != '1) begin
            next_q.cyc = q.cyc + 5'h1;
        end
        unique case (q.st)
            S_IDLE: begin
                if (q.run) begin
                    next_q.st = S_FETCH;
                    next_q.cyc = '0;
                end
            end
            S_FETCH: next_q.st = S_DECODE;
            S_DECODE: begin
                // product from operands as they stand at start
                w0 = pm_exec[FW-1:0];
                sum17 = {q.a[FW-1], q.a};
                if (w0[I_USEB]) begin
                    sum17 = w0[I_SUBB] ? sum17 - bx : sum17 + bx;
                end
                unique case (fap_mul_t'(w0[I_MUL_LSB +: 2]))
                    MUL_ZERO: mul17 = '0;
                    MUL_C: mul17 = cx;
                    MUL_MAGC: mul17 = q.c[FW-1] ? -cx : cx;
                    MUL_ONE: mul17 = (w0[I_MODE_LSB +: 2] == MODE_IA) ?
                        INT_ONE : FRAC_ONE;
                endcase
                prod34 = sum17 * mul17;
                // redundant top bit dropped
                p36 = {{3{prod34[32]}}, prod34[32:0]};
                next_q.prod = w0[I_NEG] ? -p36 : p36;
                next_q.instr = pm_exec;
                next_q.slot = '0;
                next_q.ph = 1'b0;
                next_q.st = S_MOVE;
            end
            S_MOVE: begin
                tmp_re = !q.ph && mv[MV_VALID] &&
                    fap_reg_t'(mv[MV_SRC_LSB +: MV_SEL_W]) == R_T;
                next_q.ph = !q.ph;
                if (q.ph) begin
                    if (q.slot == '0) begin
                        next_q.e = q.d;
                    end
                    unique case (fap_reg_t'(mv[MV_SRC_LSB +: MV_SEL_W]))
                        R_A: src_v = q.a;
                        R_B: src_v = q.b;
                        R_C: src_v = q.c;
                        R_D: src_v = q.d;
                        R_E: src_v = q.e;
                        R_RS: src_v = q.r;
                        R_LS: src_v = q.l;
                        R_T: src_v = tmp_rdata;
                    endcase
                    if (mv[MV_VALID]) begin
                        unique case (fap_reg_t'(mv[MV_DST_LSB +: MV_SEL_W]))
                            R_A: next_q.a = src_v;
                            R_B: next_q.b = src_v;
                            R_C: next_q.c = src_v;
                            R_D: next_q.d = src_v;
                            R_E: next_q.e = src_v;
                            R_RS: next_q.s = src_v;
                            R_LS: ;
                            R_T: begin
                                tmp_we = 1'b1;
                                tmp_wdata = src_v;
                            end
                        endcase
                    end
                    // four slots per instruction
                    if (q.slot == 2'h3) begin
                        next_q.st = S_ARITH;
                    end else begin
                        next_q.slot = q.slot + 2'h1;
                    end
                end
            end
            S_ARITH: begin
                // modes and scaling
                aln = {{20{(w0[I_ADDE] ? q.e[FW-1] : q.d[FW-1])}},
                    (w0[I_ADDE] ? q.e : q.d)};
                if (w0[I_MODE_LSB +: 2] != MODE_IA) begin
                    aln = aln <<< FRAC_SH;
                end
                if (!w0[I_ADD]) begin
                    aln = '0;
                end
                acc = w0[I_ADDSUB] ? q.prod - aln : q.prod + aln;
                unique case (fap_mode_t'(w0[I_MODE_LSB +: 2]))
                    MODE_FA: sh = FRAC_SH;
                    MODE_FASL: sh = FASL_SH;
                    MODE_FRACTION_OP_SHIFT_RIGHT: sh = FRACTION_OP_SHIFT_RIGHT_SH;
                    MODE_IA: sh = 0;
                endcase
                rnd = (sh == 0) ? acc : (acc + (ONE36 <<< (sh - 1))) >>> sh;
                ev_pos = rnd > POS_LIM;
                ev_neg = rnd < NEG_LIM;
                // zero outcome gives zero result
                next_q.r = ev_pos ? SAT_MAX : ev_neg ? SAT_MIN : rnd[FW-1:0];
                next_q.pause = w0[I_PAUSE_LSB +: PAUSE_W];
                if (w0[I_PAUSE_LSB +: PAUSE_W] != '0) begin
                    next_q.st = S_PAUSE;
                end else if (w0[I_HALT] || !q.run) begin
                    next_q.run = 1'b0;
                    next_q.st = S_IDLE;
                end else begin
                    next_q.pc = q.pc + 10'h001;
                    next_q.st = S_FETCH;
                    next_q.cyc = '0;
                end
            end
            S_PAUSE: begin
                next_q.pause = q.pause - 3'h1;
                if (q.pause == 3'h1) begin
                    if (w0[I_HALT] || !q.run) begin
                        next_q.run = 1'b0;
                        next_q.st = S_IDLE;
                    end else begin
                        next_q.pc = q.pc + 10'h001;
                        next_q.st = S_FETCH;
                        next_q.cyc = '0;
                    end
                end
            end
            default: next_q.st = S_IDLE;
        endcase

        // ********************************************************
        // status word, error flags, error line
        // ********************************************************
        processor_status_word = '0;
        processor_status_word[PSW_PAUSE_LSB +: PAUSE_W] = q.pause;
        processor_status_word[PSW_PRESENT] = 1'b1;
        processor_status_word[PSW_ACTIVE] = (q.st != S_IDLE);
        processor_status_word[PSW_NEG] = q.neg_f;
        processor_status_word[PSW_POS] = q.pos_f;
        processor_status_word[PSW_ANY] = q.any_f;
        st_rd = rd && addr == ADDR_STATUS;
        // set wins over read clear
        next_q.neg_f = (q.neg_f && !st_rd) || ev_neg;
        next_q.pos_f = (q.pos_f && !st_rd) || ev_pos;
        next_q.any_f = (q.any_f && !st_rd) || ev_neg || ev_pos;
        next_q.err_line = |(q.en & processor_status_word &
            {1'b1, 1'b1, 1'b1, 13'h0000});

        // ********************************************************
        // host port
        // ********************************************************
        next_q.rdata = '0;
        next_q.sel_pm = 1'b0;
        if (rd) begin
            unique case (addr)
                ADDR_STATUS: next_q.rdata = processor_status_word;
                ADDR_CTRL: next_q.rdata = {5'h00, q.pc, q.run};
                ADDR_LOAD: next_q.rdata = q.l;
                ADDR_STORE: next_q.rdata = q.s;
                ADDR_PC: next_q.rdata = {6'h00, q.pc};
                default: next_q.sel_pm = addr[PM_SEL_BIT];
            endcase
        end
        if (wr) begin
            unique case (addr)
                ADDR_STATUS: next_q.en = wdata;
                ADDR_CTRL: begin
                    next_q.run = wdata[CTRL_RUN];
                    if (q.st == S_IDLE) begin
                        next_q.pc = wdata[CTRL_PC_LSB +: PM_AW];
                    end
                end
                ADDR_LOAD: next_q.l = wdata;
                default: begin
                    // per-field write, unused bits dropped
                    pm_we = addr[PM_SEL_BIT] &&
                        addr[FLD_W-1:0] < FLD_W'(FIELDS);
                    pm_wdata = wdata & ((addr[FLD_W-1:0] == '0) ?
                        MASK_F0 : MASK_MV);
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= next_q;
        end
    end

    assign rdata = q.sel_pm ? pm_rdata : q.rdata;
    assign arith_error_line = q.err_line;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst || !ce);

    instr_time_a: assert property (
        q.st == S_ARITH |-> q.cyc < 5'(INSTR_CYC))
        else $error("instruction exceeds its time");
    trf_access_a: assert property (
        tmp_re |=> q.st == S_MOVE && q.ph)
        else $error("temporary file read not used next cycle");
    move_overlap_a: assert property (
        q.st == S_DECODE |=> (q.st == S_MOVE) [*8] ##1 q.st == S_ARITH)
        else $error("moves not within arithmetic window");
    status_bits_a: assert property (
        st_rd |=> rdata[PSW_PRESENT] &&
        rdata[PSW_PAUSE_LSB +: PAUSE_W] == $past(q.pause) &&
        rdata[PSW_ACTIVE] == ($past(q.st) != S_IDLE))
        else $error("status word content wrong");
    flag_set_a: assert property (
        ev_neg |=> q.neg_f && q.any_f)
        else $error("negative overflow not latched");
    flag_hold_a: assert property (
        q.pos_f && !st_rd |=> q.pos_f)
        else $error("positive flag lost without read");
    read_clear_a: assert property (
        st_rd && !ev_neg && !ev_pos |=>
        !q.any_f && rdata[PSW_ANY] == $past(q.any_f))
        else $error("status read did not clear flags");
    any_err_a: assert property (
        q.any_f == (q.neg_f || q.pos_f))
        else $error("combined flag disagrees");
    err_line_a: assert property (
        ##1 arith_error_line ==
        $past(|(q.en[PSW_ANY:PSW_NEG] & {q.any_f, q.pos_f, q.neg_f})))
        else $error("error line gating wrong");
    enable_wr_a: assert property (
        wr && addr == ADDR_STATUS && !ev_pos |=>
        q.en == $past(wdata) && q.pos_f == $past(q.pos_f))
        else $error("status address write misrouted");
    sat_pos_a: assert property (
        ev_pos |=> q.r == SAT_MAX)
        else $error("positive overflow not saturated");
    e_copy_a: assert property (
        q.st == S_MOVE && q.slot == '0 && q.ph &&
        !(mv[MV_VALID] && mv[MV_DST_LSB +: MV_SEL_W] == R_E)
        |=> q.e == $past(q.d))
        else $error("D not copied to E");

    run_c: cover property (q.st == S_ARITH ##1 q.st == S_FETCH);
    ovf_c: cover property (ev_neg ##[1:40] st_rd);
    pause_c: cover property (q.st == S_PAUSE ##1 q.st == S_PAUSE);
endmodule

// File: bench/fap_host_model.sv
// host model: master of the register port of the arithmetic processor
// assumes one calling process and the sys_clk domain
module fap_host_model import fap_pkg::*; (
    input wire logic sys_clk,
    output logic [15:0] addr,
    output logic [FW-1:0] wdata,
    output logic wr,
    output logic rd
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // one-cycle strobes, lines inverted on release
    // ****************************************
    initial begin
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
    end
    task automatic bus_write(input logic [15:0] a, input logic [FW-1:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        addr <= ~a;
        wdata <= ~d;
        wr <= 1'b0;
    endtask
    task automatic bus_read(input logic [15:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        addr <= ~a;
        rd <= 1'b0;
    endtask
endmodule

// File: bench/fap_arith_processor_test.sv
// bench: host model drives the processor, a watcher checks read data
// assumes ce held high and a 100 MHz sys_clk
module fap_arith_processor_test import fap_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rst, ce, wr, rd, rd_q, arith_error_line;
    logic [15:0] addr;
    logic [FW-1:0] wdata, rdata, d;
    logic [FW-1:0] exp_q[$];
    logic [FW-1:0] prog[15];
    int fails, n_tests, seed;
    // ****************************************
    // clock, instances, checking
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    fap_arith_processor fap_arith_processor_i (.sys_clk(sys_clk), .rst(rst),
        .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .arith_error_line(arith_error_line));
    fap_host_model fap_host_model_i (.sys_clk(sys_clk), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd));
    task automatic chk(input logic [FW-1:0] e, input logic [FW-1:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] rdata/err_line exp %h got %h", e, g);
            fails++;
        end
    endtask
    always @(posedge sys_clk) rd_q <= rd;
    always @(negedge sys_clk) begin
        if (rd_q === 1'b1 && exp_q.size() > 0) begin
            chk(exp_q.pop_front(), rdata);
        end
    end
    task automatic rd_exp(input logic [15:0] a, input logic [FW-1:0] e);
        exp_q.push_back(e);
        fap_host_model_i.bus_read(a);
    endtask
    function automatic logic [15:0] pm(input int idx, input int fld);
        return 16'h8000 | 16'(idx << 3) | 16'(fld);
    endfunction
    task automatic results();
        if (exp_q.size() != 0) begin
            $display("[FAIL] read queue exp 0 got %0d", exp_q.size());
            fails++;
        end
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // one load-compute-store program; f0 is the arithmetic field
    task automatic run_prog(input logic [FW-1:0] f0, input logic [FW-1:0] st);
        prog = '{16'h0000, 16'hE000, 16'hE400, 16'hE600, 16'hEE05,
            f0, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
            16'h8000, 16'hDA00, 16'hF205, 16'h0000, 16'h0000};
        for (int i = 0; i < 15; i++) begin
            fap_host_model_i.bus_write(pm(i / 5, i % 5), prog[i]);
        end
        fap_host_model_i.bus_write(ADDR_CTRL, 16'h0001);
        rd_exp(ADDR_STATUS, 16'h0300);
        repeat (3 * INSTR_CYC) @(posedge sys_clk);
        rd_exp(ADDR_STORE, st);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        seed = 97894;
        fails = 0;
        n_tests = 0;
        rst = 1'b1;
        ce = 1'b1;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        rd_exp(ADDR_STATUS, 16'h0100);
        fap_host_model_i.bus_write(ADDR_STATUS, 16'hFFFF);
        rd_exp(ADDR_STATUS, 16'h0100);
        fap_host_model_i.bus_write(16'h0010, 16'(($random(seed))));
        rd_exp(16'h0010, 16'h0000);
        for (int f = 0; f < 8; f++) begin
            d = 16'($random(seed));
            fap_host_model_i.bus_write(pm(1023, f), d);
            d = f == 0 ? d & MASK_F0 : (f < 5 ? d & MASK_MV : 16'h0000);
            rd_exp(pm(1023, f), d);
        end
        fap_host_model_i.bus_write(ADDR_STATUS, 16'h2000);
        fap_host_model_i.bus_write(ADDR_LOAD, 16'h4000);
        rd_exp(ADDR_LOAD, 16'h4000);
        run_prog(16'h0610, SAT_MAX);
        @(negedge sys_clk);
        chk(16'h0000, {15'h0, arith_error_line});
        rd_exp(ADDR_STATUS, 16'hC100);
        run_prog(16'h0710, SAT_MIN);
        @(negedge sys_clk);
        chk(16'h0001, {15'h0, arith_error_line});
        rd_exp(ADDR_STATUS, 16'hA100);
        rd_exp(ADDR_STATUS, 16'h0100);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(16'h0000, {15'h0, arith_error_line});
        run_prog(16'h0818, 16'h6000);
        run_prog(16'h041E, 16'hF000);
        run_prog(16'h0210, 16'h4000);
        run_prog(16'h0050, 16'h4000);
        fap_host_model_i.bus_write(ADDR_CTRL, 16'h0005);
        repeat (INSTR_CYC) @(posedge sys_clk);
        rd_exp(ADDR_STORE, 16'h0000);
        repeat (3) @(posedge sys_clk);
        results();
    end
endmodule
